// ---- rtl/ebc_defs.svh ----
// register offsets, field positions and reset values of the external bus control block
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EBC_OFF_CHIP_CFG 12'h000
`define EBC_OFF_IO_CTRL3 12'h004
`define EBC_OFF_STATUS 12'h008

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EBC_CFG_WIDTH_EN_BIT 1
`define EBC_CFG_ALE_MODE_BIT 3
`define EBC_CFG_WAIT_LO_BIT 4
`define EBC_CFG_WAIT_HI_BIT 5
`define EBC_IO_CONTROL_3_CLK_DIS_BIT 1
`define EBC_STAT_BUSY_BIT 0
`define EBC_STAT_WIDE_BIT 1
`define EBC_STAT_WAIT_LO_BIT 4
`define EBC_STAT_WAIT_HI_BIT 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EBC_CHIP_CFG_RST 8'h00
`define EBC_IO_CTRL3_RST 8'h00

`endif

// ---- rtl/ebc_pkg.sv ----
// types shared by the external bus control block
package ebc_pkg;

  typedef enum logic [1:0] {
    KIND_DATA   = 2'h0,
    KIND_FETCH  = 2'h1,
    KIND_CONFIG = 2'h2,
    KIND_VECTOR = 2'h3
  } cycle_kind_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_END  = 4'b1000
  } bus_state_e;

  typedef struct packed {
    cycle_kind_e kind;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [15:0] rdata;
    logic        wide;
  } bus_rsp_s;

endpackage

// ---- rtl/pin_sync.sv ----
// two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  initial begin
    if (W < 1) $error("pin_sync: width must be at least 1");
  end

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ---- rtl/ext_bus_ctrl.sv ----
// external bus control strobes, width select, divided clock and register slave
`timescale 1ns/1ps
`default_nettype none
`include "ebc_defs.svh"
module ext_bus_ctrl #(
  parameter int AW = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  output logic req_ready,
  input wire ebc_pkg::bus_req_s req,
  output logic rsp_valid,
  output ebc_pkg::bus_rsp_s rsp,
  input wire logic osc_input,
  input wire logic ready,
  input wire logic bus_width_select,
  input wire logic [15:0] muxed_addr_data_in,
  output logic [15:0] muxed_addr_data_out,
  output logic [15:0] muxed_addr_data_oe,
  output logic rd_n,
  output logic addr_strobe,
  output logic fetch_type_ind,
  output logic divided_clock_out,
  output logic divided_clock_oe
);
  initial begin
    if (AW != 16) $error("ext_bus_ctrl: only a 16-bit address bus is supported");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [18:0] pins_s;
  logic osc_s, ready_s, width_s;
  logic [15:0] ad_s;

  pin_sync #(.W(19)) u_sync (
    .clock(clock),
    .reset(reset),
    .d({osc_input, ready, bus_width_select, muxed_addr_data_in}),
    .q(pins_s)
  );
  assign {osc_s, ready_s, width_s, ad_s} = pins_s;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [7:0] chip_config_reg_r, chip_config_reg_nxt;
  logic [7:0] io_control_3_r, io_control_3_nxt;
  logic [31:0] prdata_nxt;
  logic [7:0] status_w;
  logic mapped;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `EBC_OFF_CHIP_CFG) || (a == `EBC_OFF_IO_CTRL3) || (a == `EBC_OFF_STATUS);
  endfunction

  assign mapped = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    chip_config_reg_nxt = chip_config_reg_r;
    io_control_3_nxt = io_control_3_r;
    prdata_nxt = prdata;
    if (psel & penable & pwrite) begin
      if (paddr == `EBC_OFF_CHIP_CFG) chip_config_reg_nxt = pwdata[7:0];
      if (paddr == `EBC_OFF_IO_CTRL3) io_control_3_nxt = pwdata[7:0];
    end
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `EBC_OFF_CHIP_CFG: prdata_nxt = {24'h00_0000, chip_config_reg_r};
        `EBC_OFF_IO_CTRL3: prdata_nxt = {24'h00_0000, io_control_3_r};
        `EBC_OFF_STATUS: prdata_nxt = {24'h00_0000, status_w};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      chip_config_reg_r <= `EBC_CHIP_CFG_RST;
      io_control_3_r <= `EBC_IO_CTRL3_RST;
      prdata <= 32'h0000_0000;
    end else begin
      chip_config_reg_r <= chip_config_reg_nxt;
      io_control_3_r <= io_control_3_nxt;
      prdata <= prdata_nxt;
    end
  end

  logic ale_mode, width_en;
  logic [1:0] wait_max;
  assign ale_mode = chip_config_reg_r[`EBC_CFG_ALE_MODE_BIT];
  assign width_en = chip_config_reg_r[`EBC_CFG_WIDTH_EN_BIT];
  assign wait_max = chip_config_reg_r[`EBC_CFG_WAIT_HI_BIT:`EBC_CFG_WAIT_LO_BIT];

  // ----------------------------------------------------------------
  // divided clock
  // ----------------------------------------------------------------
  logic osc_prev_r, osc_prev_nxt, div_r, div_nxt;
  logic osc_rise, clk_fall, clk_rise;

  assign osc_rise = osc_s & ~osc_prev_r;
  assign clk_fall = osc_rise & div_r;
  assign clk_rise = osc_rise & ~div_r;

  always_comb begin
    osc_prev_nxt = osc_s;
    div_nxt = osc_rise ? ~div_r : div_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      osc_prev_r <= 1'b0;
      div_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_prev_nxt;
      div_r <= div_nxt;
    end
  end

  assign divided_clock_out = div_r;
  assign divided_clock_oe = ~io_control_3_r[`EBC_IO_CONTROL_3_CLK_DIS_BIT];

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  ebc_pkg::bus_state_e state_r, state_nxt;
  ebc_pkg::bus_req_s cur_r, cur_nxt;
  logic wide_r, wide_nxt;
  logic [1:0] wait_cnt_r, wait_cnt_nxt, last_wait_r, last_wait_nxt;
  logic rsp_valid_nxt;
  ebc_pkg::bus_rsp_s rsp_nxt;

  assign req_ready = (state_r == ebc_pkg::ST_IDLE);
  assign status_w = {2'b00, last_wait_r, 2'b00, wide_r, ~req_ready};

  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    wide_nxt = wide_r;
    wait_cnt_nxt = wait_cnt_r;
    last_wait_nxt = last_wait_r;
    rsp_valid_nxt = 1'b0;
    rsp_nxt = rsp;
    case (state_r)
      ebc_pkg::ST_IDLE: begin
        if (req_valid & clk_rise) begin
          state_nxt = ebc_pkg::ST_ADDR;
          cur_nxt = req;
          wide_nxt = width_en & width_s;
          wait_cnt_nxt = 2'b00;
        end
      end
      ebc_pkg::ST_ADDR: begin
        if (clk_fall) state_nxt = ebc_pkg::ST_DATA;
      end
      ebc_pkg::ST_DATA: begin
        // first fall is the normal transfer slot, later ones are wait states
        if (clk_fall) begin
          if (ready_s || (wait_cnt_r == wait_max)) begin
            state_nxt = ebc_pkg::ST_END;
            last_wait_nxt = wait_cnt_r;
            rsp_valid_nxt = 1'b1;
            rsp_nxt.wide = wide_r;
            rsp_nxt.rdata = cur_r.write ? 16'h0000 : (wide_r ? ad_s : {8'h00, ad_s[7:0]});
          end else begin
            wait_cnt_nxt = wait_cnt_r + 2'b01;
          end
        end
      end
      ebc_pkg::ST_END: begin
        if (clk_rise) state_nxt = ebc_pkg::ST_IDLE;
      end
      default: state_nxt = ebc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ebc_pkg::ST_IDLE;
      cur_r <= '0;
      wide_r <= 1'b0;
      wait_cnt_r <= 2'b00;
      last_wait_r <= 2'b00;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      wide_r <= wide_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      last_wait_r <= last_wait_nxt;
      rsp_valid <= rsp_valid_nxt;
      rsp <= rsp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, registered from the next state
  // ----------------------------------------------------------------
  logic rd_n_nxt, strobe_nxt, fetch_nxt;
  logic [15:0] ad_out_nxt, ad_oe_nxt;
  ebc_pkg::bus_req_s nreq;
  logic nwide;

  always_comb begin
    nreq = cur_nxt;
    nwide = wide_nxt;
    rd_n_nxt = 1'b1;
    strobe_nxt = ~ale_mode;
    fetch_nxt = 1'b0;
    ad_out_nxt = 16'h0000;
    ad_oe_nxt = 16'h0000;
    if (state_nxt != ebc_pkg::ST_IDLE) begin
      fetch_nxt = (nreq.kind == ebc_pkg::KIND_FETCH);
    end
    case (state_nxt)
      ebc_pkg::ST_ADDR: begin
        strobe_nxt = ale_mode ? 1'b1 : 1'b0;
        ad_out_nxt = nreq.addr;
        ad_oe_nxt = 16'hFFFF;
      end
      ebc_pkg::ST_DATA: begin
        strobe_nxt = ~ale_mode ? 1'b0 : 1'b0;
        rd_n_nxt = nreq.write;
        if (nwide) begin
          ad_out_nxt = nreq.wdata;
          ad_oe_nxt = nreq.write ? 16'hFFFF : 16'h0000;
        end else begin
          ad_out_nxt = {nreq.addr[15:8], nreq.wdata[7:0]};
          ad_oe_nxt = {8'hFF, nreq.write ? 8'hFF : 8'h00};
        end
      end
      ebc_pkg::ST_END: begin
        strobe_nxt = ~ale_mode;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_n <= 1'b1;
      addr_strobe <= 1'b1;
      fetch_type_ind <= 1'b0;
      muxed_addr_data_out <= 16'h0000;
      muxed_addr_data_oe <= 16'h0000;
    end else begin
      rd_n <= rd_n_nxt;
      addr_strobe <= strobe_nxt;
      fetch_type_ind <= fetch_nxt;
      muxed_addr_data_out <= ad_out_nxt;
      muxed_addr_data_oe <= ad_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence div_toggle_s;
    osc_rise ##1 (divided_clock_out != $past(divided_clock_out));
  endsequence

  sequence wait_expire_s;
    (state_r == ebc_pkg::ST_DATA) && clk_fall && ~ready_s && (wait_cnt_r == wait_max);
  endsequence

  rd_only_read_a: assert property (@(posedge clock) disable iff (reset)
    !rd_n |-> (state_r == ebc_pkg::ST_DATA) && !cur_r.write)
    else $error("read strobe low outside a read transfer");
  ale_start_a: assert property (@(posedge clock) disable iff (reset)
    (ale_mode && addr_strobe && $stable(chip_config_reg_r)) |-> (state_r == ebc_pkg::ST_ADDR))
    else $error("latch strobe high outside address phase");
  adv_select_a: assert property (@(posedge clock) disable iff (reset)
    (!ale_mode && $stable(chip_config_reg_r) && (state_r == ebc_pkg::ST_ADDR)) |-> !addr_strobe)
    else $error("address valid not low in address phase");
  adv_ext_a: assert property (@(posedge clock) disable iff (reset)
    (!ale_mode && $stable(chip_config_reg_r) && !addr_strobe) |-> (state_r != ebc_pkg::ST_IDLE))
    else $error("address valid low while idle");
  adv_release_a: assert property (@(posedge clock) disable iff (reset)
    (!ale_mode && $stable(chip_config_reg_r) && (state_r == ebc_pkg::ST_DATA)) |-> !addr_strobe)
    else $error("address valid not held low through data phase");
  adv_end_a: assert property (@(posedge clock) disable iff (reset)
    (!ale_mode && $stable(chip_config_reg_r) && (state_r == ebc_pkg::ST_END)) |-> addr_strobe)
    else $error("address valid not released at cycle end");
  fetch_kind_a: assert property (@(posedge clock) disable iff (reset)
    (state_r != ebc_pkg::ST_IDLE) |-> fetch_type_ind == (cur_r.kind == ebc_pkg::KIND_FETCH))
    else $error("fetch type indicator wrong");
  data_class_a: assert property (@(posedge clock) disable iff (reset)
    ((cur_r.kind == ebc_pkg::KIND_CONFIG) || (cur_r.kind == ebc_pkg::KIND_VECTOR)) |-> !fetch_type_ind)
    else $error("config or vector fetch flagged as instruction");
  width_gate_a: assert property (@(posedge clock) disable iff (reset)
    ((state_r == ebc_pkg::ST_IDLE) && (state_nxt == ebc_pkg::ST_ADDR) && !width_en) |=> !wide_r)
    else $error("wide cycle while width pin disabled");
  clk_half_a: assert property (@(posedge clock) disable iff (reset)
    osc_rise |-> div_toggle_s)
    else $error("divided clock did not toggle on oscillator edge");
  clk_enable_a: assert property (@(posedge clock) disable iff (reset)
    (psel && penable && pwrite && (paddr == `EBC_OFF_IO_CTRL3)) |=> (divided_clock_oe == !$past(pwdata[1])))
    else $error("clock output enable does not follow the written control bit");
  wait_bound_a: assert property (@(posedge clock) disable iff (reset)
    wait_expire_s |=> (state_r == ebc_pkg::ST_END) && rsp_valid)
    else $error("wait states exceeded programmed maximum");
  upper_addr_a: assert property (@(posedge clock) disable iff (reset)
    ((state_r == ebc_pkg::ST_DATA) && !wide_r) |->
    (muxed_addr_data_oe[15:8] == 8'hFF) && (muxed_addr_data_out[15:8] == cur_r.addr[15:8]))
    else $error("upper pins not carrying address in 8-bit cycle");
  idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
    ((state_r == ebc_pkg::ST_IDLE) && $stable(chip_config_reg_r)) |-> rd_n && (addr_strobe == !ale_mode))
    else $error("strobes active while idle");
endmodule // ext_bus_ctrl
`default_nettype wire

// ---- verif/ext_mem_model.sv ----
// external memory model with address latch and pulled-up data lines
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic clock,
  input wire logic rd_n,
  input wire logic addr_strobe,
  input wire logic latch_mode,
  input wire logic stall,
  input wire logic wide_pin,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  output logic ready,
  output logic bus_width_select,
  output logic [15:0] ad_in
);
  logic [15:0] latched;
  initial latched = 16'h0000;
  // undriven lines sit at the pull-up level while rd_n is high, and carry the latched value xor 5a5a while it is low
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & (rd_n ? 16'hffff : latched ^ 16'h5a5a));
  assign ready = ~stall;
  assign bus_width_select = wide_pin;
  always @(posedge clock) begin
    if (rd_n && (latch_mode ? addr_strobe : !addr_strobe)) latched <= ad_in;
  end
endmodule // ext_mem_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the external bus control block
`timescale 1ns/1ps
`default_nettype none
`include "ebc_defs.svh"
module tb_top;
  logic clock, reset, osc_input, psel, penable, pwrite, pready, pslverr;
  logic req_valid, req_ready, rsp_valid, stall, wide_pin, ready, bus_width_select;
  logic rd_n, addr_strobe, fetch_type_ind, divided_clock_out, divided_clock_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] ad_in, ad_out, ad_oe;
  logic [7:0] cfg;
  ebc_pkg::bus_req_s req;
  ebc_pkg::bus_rsp_s rsp;
  int num_errors, n_checks, ticks;

  ext_bus_ctrl uut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .osc_input(osc_input), .ready(ready), .bus_width_select(bus_width_select),
    .muxed_addr_data_in(ad_in), .muxed_addr_data_out(ad_out), .muxed_addr_data_oe(ad_oe),
    .rd_n(rd_n), .addr_strobe(addr_strobe), .fetch_type_ind(fetch_type_ind),
    .divided_clock_out(divided_clock_out), .divided_clock_oe(divided_clock_oe));
  ext_mem_model mem (.clock(clock), .rd_n(rd_n), .addr_strobe(addr_strobe),
    .latch_mode(cfg[`EBC_CFG_ALE_MODE_BIT]), .stall(stall), .wide_pin(wide_pin), .ad_out(ad_out),
    .ad_oe(ad_oe), .ready(ready), .bus_width_select(bus_width_select), .ad_in(ad_in));

  always #10 clock = ~clock;
  // oscillator free-runs with its own phase offset
  initial begin
    osc_input = 1'b0;
    #3;
    forever #80 osc_input = ~osc_input;
  end
  always @(posedge clock) begin
    ticks++;
    if (ticks == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----
  // helpers
  // ----
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] exp_data(input logic [15:0] a, input logic w);
    logic [15:0] m;
    m = a ^ 16'h5a5a;
    return w ? m : {8'h00, m[7:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_cfg(input logic [7:0] v);
    logic [31:0] q;
    logic e;
    cfg = v;
    apb(1'b1, `EBC_OFF_CHIP_CFG, {24'h0, v}, q, e);
  endtask
  task automatic bus_cycle(input logic [1:0] k, input logic wr, input logic [15:0] a, input logic [15:0] wd);
    int lo, hi, exp_lo;
    logic wide;
    lo = 0;
    hi = 0;
    // let pin changes pass the input synchronisers first
    repeat (4) @(posedge clock);
    wide = cfg[`EBC_CFG_WIDTH_EN_BIT] & wide_pin;
    exp_lo = stall ? 16 * (1 + int'(cfg[5:4])) : 16;
    req_valid <= 1'b1;
    req <= '{kind: ebc_pkg::cycle_kind_e'(k), write: wr, addr: a, wdata: wd};
    do @(negedge clock); while (req_ready === 1'b1);
    @(posedge clock);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1) begin
      @(negedge clock);
      if (addr_strobe === 1'b1) hi++;
      if (wr) chk(rd_n, 1'b1);
      if (rd_n === 1'b0) begin
        lo++;
        chk(addr_strobe, 1'b0);
        chk(fetch_type_ind, k == ebc_pkg::KIND_FETCH);
        chk(ad_oe[15:8], wide ? 8'h00 : 8'hff);
        if (!wide) chk(ad_out[15:8], a[15:8]);
      end
    end
    if (!wr) chk(rsp.rdata, exp_data(a, wide));
    chk(rsp.wide, wide);
    while (req_ready !== 1'b1) begin
      @(negedge clock);
      if (rd_n === 1'b0) lo++;
    end
    @(negedge clock);
    chk(rd_n, 1'b1);
    chk(addr_strobe, !cfg[`EBC_CFG_ALE_MODE_BIT]);
    if (cfg[`EBC_CFG_ALE_MODE_BIT]) chk(hi > 0, 1'b1);
    if (!wr) chk(lo >= exp_lo - 1 && lo <= exp_lo + 1, 1'b1);
  endtask
  task automatic measure_clk();
    int h, l;
    h = 0;
    l = 0;
    while (divided_clock_out !== 1'b0) @(negedge clock);
    while (divided_clock_out !== 1'b1) @(negedge clock);
    while (divided_clock_out === 1'b1) begin h++; @(negedge clock); end
    while (divided_clock_out === 1'b0) begin l++; @(negedge clock); end
    chk(h, 8);
    chk(l, 8);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] q, r;
    logic e;
    clock = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, req_valid, stall} = 5'h00;
    wide_pin = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    req = '0;
    cfg = 8'h00;
    seed = 32'h260a_9407;
    num_errors = 0;
    n_checks = 0;
    ticks = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk(rd_n, 1'b1);
    chk(addr_strobe, 1'b1);
    chk(divided_clock_oe, 1'b1);
    apb(1'b0, `EBC_OFF_CHIP_CFG, 32'h0, q, e);
    chk(q, {24'h0, `EBC_CHIP_CFG_RST});
    apb(1'b0, 12'h0f0, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, `EBC_OFF_IO_CTRL3, 32'h0000_0002, q, e);
    @(negedge clock);
    chk(divided_clock_oe, 1'b0);
    apb(1'b1, `EBC_OFF_IO_CTRL3, 32'h0, q, e);
    @(negedge clock);
    chk(divided_clock_oe, 1'b1);
    measure_clk();
    // every cycle kind in both strobe modes, width pin high but gated off in the first
    for (int m = 0; m < 2; m++) begin
      set_cfg(m ? 8'h0a : 8'h00);
      for (int k = 0; k < 4; k++) bus_cycle(k[1:0], 1'b0, 16'(rnd() >> 16), 16'h0000);
    end
    bus_cycle(2'h0, 1'b1, 16'hc3a5, 16'h1234);
    set_cfg(8'h20);
    stall <= 1'b1;
    bus_cycle(2'h1, 1'b0, 16'h8001, 16'h0000);
    set_cfg(8'h32);
    bus_cycle(2'h0, 1'b0, 16'hffff, 16'h0000);
    // three waits ran out on a wide cycle, and the sequencer is idle again
    apb(1'b0, `EBC_OFF_STATUS, 32'h0, q, e);
    chk(q, (32'h0000_0003 << `EBC_STAT_WAIT_LO_BIT) | (32'h0000_0001 << `EBC_STAT_WIDE_BIT));
    stall <= 1'b0;
    repeat (12) begin
      r = rnd();
      set_cfg({2'b00, r[5:4], r[3], 1'b0, r[1], 1'b0});
      wide_pin <= r[8];
      stall <= r[9];
      bus_cycle(r[11:10], r[12], r[31:16], 16'(rnd() >> 16));
    end
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
